// ### synth_loader_pkg.sv
package synth_loader_pkg;

    // Program word geometry, first-shifted field at the top
    localparam int unsigned PROG_BITS   = 32;
    localparam int unsigned PRE_LSB     = 28;
    localparam int unsigned UPPER_LSB   = 23;
    localparam int unsigned LOWER_LSB   = 18;
    localparam int unsigned PRESC_LSB   = 14;
    localparam int unsigned FACT_LSB    = 11;
    localparam int unsigned OUTDIV_LSB  = 6;
    localparam int unsigned NUM_LSB     = 3;
    localparam int unsigned DEN_LSB     = 0;

    // Lock qualification count in reference clocks
    localparam logic [8:0]  LOCK_COUNT  = 9'h100;

    // Post-divider code boundaries
    localparam logic [4:0]  OUTDIV_STEP2 = 5'h10;
    localparam logic [4:0]  OUTDIV_STEP4 = 5'h18;

    // Decoded program fields
    typedef struct packed {
        logic [4:0] upper_count_field;
        logic [4:0] lower_count_field;
        logic [3:0] prescale_select;
        logic [5:0] output_divisor;
        logic [5:0] numerator_divisor;
        logic [5:0] denominator_divisor;
    } synth_cfg_t;

    // Wrapper divider table, shared by numerator and denominator
    function automatic logic [5:0] wrap_div(input logic [2:0] code);
        logic [5:0] d;
        d = 6'h10;
        unique case (code)
            3'h0, 3'h1: d = 6'h10;
            3'h2:       d = 6'h12;
            3'h3:       d = 6'h11;
            3'h4:       d = 6'h1f;
            3'h5:       d = 6'h0e;
            3'h6:       d = 6'h20;
            3'h7:       d = 6'h0f;
        endcase
        return d;
    endfunction

    // Output post-divider table
    function automatic logic [5:0] out_div(input logic [4:0] code);
        logic [5:0] d;
        d = 6'h01;
        if (code == 5'h00) begin
            d = 6'h01;
        end else if (code == 5'h01) begin
            d = 6'h03;
        end else if (code < OUTDIV_STEP2) begin
            d = {1'b0, code};
        end else if (code < OUTDIV_STEP4) begin
            d = 6'h10 + {2'h0, code[2:0], 1'b0};
        end else begin
            d = 6'h20 + {1'b0, code[2:0], 2'h0};
        end
        return d;
    endfunction

endpackage

// ### synth_program_loader.sv
// Operation
// [R1] Numerator select decodes by wrapper table
// [R2] Output select decodes to 1..60 divisor
// [R3] Post-divider guarantees rising edges only
// [R4] Wrapper output post-divided before output pin
// [R5] Select high: shift data on clock rise
// [R6] Select low: serial activity ignored
// [R7] Select fall starts acquisition of program
// [R8] Host toggles select to re-acquire
// [R9] Host shifts 32 bits, waits lock
// [R10] Word field order fixed, zero fields
// [R11] Multi-bit fields travel MSB first
// [R12] Standard programs use code 101 twice
// [R13] 622.08 MHz example program word
// [R14] 51.84 MHz example program word
// [R15] Denominator select uses same table
// [R16] Host keeps divisors within one set
// [R17] Lock after 256 clean reference clocks
// [R18] Old settings hold until select falls
`timescale 1ns/1ps
module synth_program_loader
    import synth_loader_pkg::*;
(
    input  wire logic mclk,                // Reference-side clock
    input  wire logic srst,                // Synchronous reset, active high
    input  wire logic serial_shift_clock,  // Link clock from host
    input  wire logic serial_data_in,      // Serial program data
    input  wire logic program_select,      // Frame select, active high
    input  wire logic wrap_clk_in,         // Wrapper synth output, sampled
    input  wire logic phase_err,           // Large phase error, one per ref clock
    output synth_cfg_t cfg,                // Applied divider settings
    output logic      acq_start,           // One-cycle acquisition start
    output logic      locked,              // Lock indication
    output logic      synth_output         // Post-divided clock
);

    // Link domain: shift register, only loaded while select is high
    logic [PROG_BITS-1:0] shift_r;         // Bits shifted in this frame

    // Shift when select is high; select low gates the link off
    always_ff @(posedge serial_shift_clock) begin
        if (program_select) begin          // see [R5] see [R6]
            shift_r <= {shift_r[PROG_BITS-2:0], serial_data_in}; // see [R11]
        end
    end

    // Select level carried into mclk through two flops, plus one of history.
    // The frame end is found as a fall of the synced level, so no flop is
    // clocked by the select pin and the link side needs no reset at all.
    // Limitation: select must stay high, and then low, for at least two
    // mclk periods, or the reference side can miss the frame end.
    logic [2:0] sel_sync_r;                // [0] meta, [1] stable, [2] history
    always_ff @(posedge mclk) begin
        if (srst) begin
            sel_sync_r <= 3'h0;            // Idle low level, so no false fall
        end else begin
            sel_sync_r <= {sel_sync_r[1:0], program_select};
        end
    end

    // Frame completion pulse in mclk domain, one cycle per select fall
    logic frame_done;
    assign frame_done = sel_sync_r[2] & ~sel_sync_r[1]; // see [R7]

    // Apply fields only after the frame ended; the shift register is quiet
    // by then because the shift is enabled only while select is high.
    always_ff @(posedge mclk) begin
        if (srst) begin
            cfg <= '0;
        end else if (frame_done) begin     // see [R18] see [R10]
            cfg.upper_count_field   <= shift_r[UPPER_LSB +: 5];
            cfg.lower_count_field   <= shift_r[LOWER_LSB +: 5];
            cfg.prescale_select     <= shift_r[PRESC_LSB +: 4];
            cfg.output_divisor      <= out_div(shift_r[OUTDIV_LSB +: 5]); // see [R2]
            cfg.numerator_divisor   <= wrap_div(shift_r[NUM_LSB +: 3]);   // see [R1]
            cfg.denominator_divisor <= wrap_div(shift_r[DEN_LSB +: 3]);   // see [R15]
        end
    end

    // Acquisition start pulse, raised at the same edge as the fields land
    always_ff @(posedge mclk) begin
        if (srst) begin
            acq_start <= 1'b0;
        end else begin
            acq_start <= frame_done;       // see [R7]
        end
    end

    // Lock counter: 256 clean reference clocks, any error restarts
    // Lock loss after lock is not modelled here; only a new acquisition
    // or a reset takes the lock indication down again.
    logic [8:0] lock_cnt_r;
    always_ff @(posedge mclk) begin
        if (srst || acq_start) begin
            lock_cnt_r <= 9'h000;
            locked     <= 1'b0;
        end else if (!locked) begin
            if (phase_err) begin
                lock_cnt_r <= 9'h000;      // see [R17]
            end else if (lock_cnt_r == LOCK_COUNT - 9'h001) begin
                locked     <= 1'b1;        // see [R17]
                lock_cnt_r <= 9'h000;
            end else begin
                lock_cnt_r <= lock_cnt_r + 9'h001;
            end
        end
    end

    // Wrapper clock sampled through two flops, then rising edge found
    // It must run well below half of mclk, or its edges are lost here.
    logic [2:0] wrap_sync_r;
    always_ff @(posedge mclk) begin
        if (srst) begin
            wrap_sync_r <= 3'h0;
        end else begin
            wrap_sync_r <= {wrap_sync_r[1:0], wrap_clk_in};
        end
    end
    logic wrap_rise;
    assign wrap_rise = wrap_sync_r[1] & ~wrap_sync_r[2];

    // Post-divider: one-count-wide high pulse per N input edges; duty is
    // not balanced, only the rising edge spacing is exact.
    logic [5:0] div_cnt_r;
    always_ff @(posedge mclk) begin
        if (srst) begin
            div_cnt_r    <= 6'h00;
            synth_output <= 1'b0;
        end else if (wrap_rise) begin      // see [R4]
            if (div_cnt_r + 6'h01 >= cfg.output_divisor) begin
                div_cnt_r    <= 6'h00;
                synth_output <= 1'b1;      // see [R3]
            end else begin
                div_cnt_r    <= div_cnt_r + 6'h01;
                synth_output <= (cfg.output_divisor == 6'h01); // Divide by one
            end
        end else if (cfg.output_divisor != 6'h01) begin
            synth_output <= 1'b0;
        end else begin
            synth_output <= 1'b0;
        end
    end

    // Assertions, reference clock domain unless the link clock is named
    // Every frame end is followed by a start pulse
    AST_ACQ_AFTER_FRAME: assert property (@(posedge mclk) disable iff (srst) // see [R7]
        frame_done |=> acq_start)
        else $error("No start after frame");

    // Settings move only at the edge after a frame end
    AST_CFG_HOLD: assert property (@(posedge mclk) disable iff (srst) // see [R18]
        !frame_done |=> $stable(cfg))
        else $error("Config moved mid-frame");

    // A new acquisition always drops lock
    AST_LOCK_DROP: assert property (@(posedge mclk) disable iff (srst) // see [R17]
        acq_start |=> !locked)
        else $error("Lock kept over acquire");

    // Any large error before lock restarts the count
    AST_LOCK_ERR: assert property (@(posedge mclk) disable iff (srst) // see [R17]
        (!locked && phase_err) |=> (lock_cnt_r == 9'h000))
        else $error("Error kept count");

    // Lock rises only at the end of a full clean run
    AST_LOCK_RISE: assert property (@(posedge mclk) disable iff (srst) // see [R17]
        $rose(locked) |-> ($past(lock_cnt_r) == LOCK_COUNT - 9'h001))
        else $error("Early lock");

    // Once locked, only a new acquisition or a reset takes the lock away
    AST_LOCK_HOLD: assert property (@(posedge mclk) disable iff (srst) // see [R17]
        (locked && !acq_start) |=> locked)
        else $error("Lock lost without acquire");

    // Decoded numerator divisor stays inside the table's span
    AST_NUM_RANGE: assert property (@(posedge mclk) disable iff (srst) // see [R1]
        acq_start |-> (cfg.numerator_divisor >= 6'h0e && cfg.numerator_divisor <= 6'h20))
        else $error("Bad numerator");

    // Decoded denominator divisor stays inside the same span
    AST_DEN_RANGE: assert property (@(posedge mclk) disable iff (srst) // see [R15]
        acq_start |-> (cfg.denominator_divisor >= 6'h0e && cfg.denominator_divisor <= 6'h20))
        else $error("Bad denominator");

    // Decoded output divisor stays between 1 and 60
    AST_OUT_RANGE: assert property (@(posedge mclk) disable iff (srst) // see [R2]
        acq_start |-> (cfg.output_divisor >= 6'h01 && cfg.output_divisor <= 6'h3c))
        else $error("Bad output divisor");

    // Above divide by one the output pulse lasts a single cycle
    AST_PULSE_SHORT: assert property (@(posedge mclk) disable iff (srst) // see [R3]
        (synth_output && cfg.output_divisor != 6'h01) |=> !synth_output)
        else $error("Output pulse too long");

    // Every output rising edge is launched by a wrapper rising edge
    AST_OUT_EDGE: assert property (@(posedge mclk) disable iff (srst) // see [R4]
        $rose(synth_output) |-> $past(wrap_rise))
        else $error("Output edge without wrapper edge");

    // Link clock domain: a rise with select high takes the data bit
    AST_SHIFT_TAKE: assert property (@(posedge serial_shift_clock) // see [R5]
        program_select |=> (shift_r[0] == $past(serial_data_in)))
        else $error("Serial bit not taken");

    // Link clock domain: rises with select low leave the word alone
    AST_SHIFT_IDLE: assert property (@(posedge serial_shift_clock) // see [R6]
        !program_select |=> $stable(shift_r))
        else $error("Word moved with select low");

    // Reset clears every output register by the next edge
    AST_RST_CLEAR: assert property (@(posedge mclk)
        srst |=> (cfg == '0 && !acq_start && !locked && !synth_output))
        else $error("Outputs not cleared by reset");

    // Main scenarios to be reached
    COV_FRAME: cover property (@(posedge mclk) disable iff (srst) frame_done);
    COV_LOCK: cover property (@(posedge mclk) disable iff (srst) $rose(locked));
    COV_OUT: cover property (@(posedge mclk) disable iff (srst) $rose(synth_output));
    COV_RESTART: cover property (@(posedge mclk) disable iff (srst)
        !locked && phase_err && lock_cnt_r != 9'h000);
    COV_LINK_IDLE: cover property (@(posedge serial_shift_clock) !program_select);

endmodule

// ### host_model.sv
`timescale 1ns/1ps
// Host side of the serial program link; link clock also pulses with select low in reacq
module host_model (
    output logic serial_shift_clock,  // Link clock, 6 ns period in frames
    output logic serial_data_in,      // Serial program data
    output logic program_select       // Frame select, active high
);
    initial begin
        serial_shift_clock = 1'b0;
        serial_data_in     = 1'b0;
        program_select     = 1'b0;
    end
    // Whole 32-bit word, first bit out is bit 31
    task automatic send(input logic [31:0] word);
        program_select = 1'b1;
        #5;
        for (int i = 31; i >= 0; i--) begin
            serial_data_in = word[i];
            #3 serial_shift_clock = 1'b1;
            #3 serial_shift_clock = 1'b0;
        end
        // Released line shows the inverse so a stale bit cannot pass
        serial_data_in = ~serial_data_in;
        #5 program_select = 1'b0;
    endtask
    // Noise with select low, then a bare select pulse to re-acquire; the
    // pulse spans three reference periods so the far side cannot miss it
    task automatic reacq();
        repeat (5) begin
            serial_data_in = ~serial_data_in;
            #3 serial_shift_clock = 1'b1;
            #3 serial_shift_clock = 1'b0;
        end
        program_select = 1'b1;
        #150 program_select = 1'b0;
    endtask
endmodule

// ### synth_program_loader_tb.sv
`timescale 1ns/1ps
module synth_program_loader_tb;
    import synth_loader_pkg::*;
    logic       mclk, srst, wrap_clk_in, phase_err;        // Bench-driven inputs
    logic       serial_shift_clock, serial_data_in, program_select; // Link
    synth_cfg_t cfg;                                        // Applied settings
    logic       acq_start, locked, synth_output;            // Status outputs
    int         fail_count = 0;
    int         total_checks = 0;
    int         seed = 19016;
    int         wcnt = 0;                                   // Wrapper clock divider
    synth_cfg_t exp_q[$];                                   // Expected applied settings
    logic [5:0] wtab [8] = '{6'h10, 6'h10, 6'h12, 6'h11, 6'h1f, 6'h0e, 6'h20, 6'h0f};
    logic [2:0] den_pick [8] = '{3'h7, 3'h2, 3'h5, 3'h0, 3'h6, 3'h3, 3'h4, 3'h1}; // Same set

    synth_program_loader u_synth_program_loader (.mclk(mclk), .srst(srst),
        .serial_shift_clock(serial_shift_clock), .serial_data_in(serial_data_in),
        .program_select(program_select), .wrap_clk_in(wrap_clk_in), .phase_err(phase_err),
        .cfg(cfg), .acq_start(acq_start), .locked(locked), .synth_output(synth_output));
    host_model u_host_model (.serial_shift_clock(serial_shift_clock),
        .serial_data_in(serial_data_in), .program_select(program_select));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Wrapper clock at mclk/6, slow enough for the sampling flops
    always @(posedge mclk) begin
        wcnt <= (wcnt == 2) ? 0 : wcnt + 1;
        if (wcnt == 2) wrap_clk_in <= ~wrap_clk_in;
    end
    // Expected decode, written independently of the design's tables
    function automatic synth_cfg_t exp_cfg(input logic [31:0] w);
        synth_cfg_t c;
        int         k;
        k = w[10:6];
        c.upper_count_field   = w[27:23];
        c.lower_count_field   = w[22:18];
        c.prescale_select     = w[17:14];
        c.output_divisor      = 6'((k == 0) ? 1 : (k == 1) ? 3 : (k < 16) ? k :
                                   (k < 24) ? 2 * k - 16 : 4 * k - 64);
        c.numerator_divisor   = wtab[w[5:3]];
        c.denominator_divisor = wtab[w[2:0]];
        return c;
    endfunction
    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (exp !== got) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Monitor: each acquisition start takes the oldest note
    always @(posedge mclk) begin
        if (acq_start === 1'b1) begin
            if (exp_q.size() == 0) check_val("acq_spurious", 32'h0, 32'h1);
            else check_val("cfg", exp_q.pop_front(), cfg);
        end
    end
    task automatic wait_acq();
        for (int k = 0; k < 20 && acq_start !== 1'b1; k++) @(posedge mclk);
        repeat (2) @(posedge mclk);
    endtask
    task automatic frame(input logic [31:0] w);
        synth_cfg_t prev;
        prev = cfg;
        exp_q.push_back(exp_cfg(w));
        u_host_model.send(w);
        check_val("cfg_held", prev, cfg);
        wait_acq();
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #2000000;
        fail_count++;
        close_out();
    end
    initial begin
        logic [31:0] w;
        int          edges, pulses, diff;
        srst = 1'b1;
        phase_err = 1'b0;
        wrap_clk_in = 1'b0;
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        check_val("cfg_rst", 32'h0, cfg);
        check_val("lock_rst", 32'h0, {31'h0, locked});
        frame(32'h01e1c02d);
        frame(32'h00e1c32d);
        // Every post-divider code, every wrapper code on both selects
        for (int i = 0; i < 32; i++) begin
            w = $random(seed);
            w[31:28] = 4'h0;
            w[13:11] = 3'h0;
            w[10:6] = i[4:0];
            w[5:3] = i[2:0];
            w[2:0] = den_pick[i[2:0]];
            frame(w);
        end
        exp_q.push_back(exp_cfg(w));
        u_host_model.reacq();
        wait_acq();
        // Random large errors, last one 40 cycles in; lock needs 256 clean clocks
        repeat (39) begin
            @(posedge mclk);
            phase_err <= 1'($random(seed));
        end
        @(posedge mclk);
        phase_err <= 1'b1;
        @(posedge mclk);
        phase_err <= 1'b0;
        repeat (250) @(posedge mclk);
        check_val("unlocked", 32'h0, {31'h0, locked});
        repeat (12) @(posedge mclk);
        check_val("locked", 32'h1, {31'h0, locked});
        frame(32'h0000c0ed);
        edges = 0;
        pulses = 0;
        repeat (180) begin
            @(posedge mclk);
            if (wcnt == 0 && wrap_clk_in === 1'b1) edges++;
            if (synth_output === 1'b1) pulses++;
        end
        diff = pulses * 3 - edges;
        check_val("postdiv", 32'h1, {31'h0, diff >= -3 && diff <= 3});
        check_val("queue_left", 32'h0, exp_q.size());
        close_out();
    end
endmodule
